//--- kdb_gen.sv
`timescale 1ns/1ps
// One pin-event generator with debounce and edge/level mode
module kdb_gen
  import kdb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic tick,
  input wire logic pinIn,
  input wire logic polarity,
  input wire logic debEn,
  input wire logic edgeMode,
  input wire logic [KDB_DEB_W-1:0] debTime,
  input wire logic flagClear,
  // Event to the sticky flag
  output logic fire
);
  typedef enum logic [3:0] {
    G_IDLE = 4'b0001,
    G_DEB = 4'b0010,
    G_HELD = 4'b0100,
    G_WREL = 4'b1000
  } kdb_gst_e;

  kdb_gst_e st_r, st_nxt; // State
  logic [KDB_DEB_W-1:0] cnt_r, cnt_nxt; // Debounce count
  logic prev_r; // Previous active-level sample
  logic hit; // Input at active level
  logic rise; // Active edge

  assign hit = pinIn ^ polarity;
  assign rise = hit & ~prev_r;

  // Next state
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    fire = 1'b0;
    unique case (st_r)
      G_IDLE:
      begin
        // Edge starts debounce; level mode restarts on held level
        if (rise || (!edgeMode && hit))
        begin
          if (!debEn || debTime == '0)
          begin
            fire = 1'b1;
            st_nxt = G_HELD;
          end
          else
          begin
            cnt_nxt = debTime;
            st_nxt = G_DEB;
          end
        end
      end
      G_DEB:
      begin
        if (!hit)
          st_nxt = G_IDLE; // Bounce aborts
        else if (tick)
        begin
          if (cnt_r == 6'(1))
          begin
            fire = 1'b1;
            st_nxt = G_HELD;
          end
          cnt_nxt = cnt_r - 6'(1);
        end
      end
      G_HELD:
      begin
        // Wait for software to clear the flag
        if (flagClear)
          st_nxt = edgeMode ? G_WREL : G_IDLE;
      end
      G_WREL:
      begin
        if (!hit)
          st_nxt = G_IDLE;
      end
    endcase
  end

  // Register state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= G_IDLE;
      cnt_r <= '0;
      prev_r <= 1'b1; // No edge right after reset
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      prev_r <= hit;
    end
  end

  // Edge mode parks in wait-for-release after a clear, with no new event
  property p_gen_wrel;
    @(posedge clk) disable iff (rst) (st_r == G_HELD && flagClear && edgeMode) |=> (st_r == G_WREL && !fire);
  endproperty
  a_gen_wrel: assert property (p_gen_wrel) else $error("edge mode did not wait for release");
  // An event only leaves while the input is still at its active level
  property p_gen_hit;
    @(posedge clk) disable iff (rst) fire |-> hit;
  endproperty
  a_gen_hit: assert property (p_gen_hit) else $error("generator fired with input inactive");
endmodule

//--- kdb_keys.sv
`timescale 1ns/1ps
// Keys and switches on the port pins, with optional contact chatter
module kdb_keys
(
  // Clock
  input wire logic clk,
  // Commanded key levels and chatter request
  input wire logic [11:0] press,
  input wire logic bounce,
  // Pin levels seen by the block
  output logic [11:0] pins
);
  logic [11:0] last; // Level commanded one cycle ago
  logic [11:0] mask; // Pins still chattering
  int chat; // Chatter cycles left
  initial
  begin
    pins = '0;
    last = '0;
    mask = '0;
    chat = 0;
  end
  // A changed key chatters for three cycles before it settles
  always @(posedge clk)
  begin
    last <= press;
    if (press !== last && bounce)
    begin
      mask <= press ^ last;
      chat <= 3;
      pins <= pins ^ (press ^ last);
    end
    else if (chat > 0)
    begin
      chat <= chat - 1;
      pins <= (chat == 1) ? press : pins ^ mask;
    end
    else
      pins <= press;
  end
endmodule

//--- kdb_pkg.sv
package kdb_pkg;
  // Geometry
  localparam int KDB_PINS = 12;
  localparam int KDB_GENS = 5;
  localparam int KDB_DEB_W = 6;
  localparam int KDB_SEL_W = 4;
  // Tick prescaler: 1 ms at 50 MHz
  localparam int KDB_CLK_HZ = 50000000;
  localparam int KDB_TICK_MS = 1;
  localparam int KDB_TICK_CYC = KDB_CLK_HZ / 1000 * KDB_TICK_MS;
  // Register byte addresses (4 * register index)
  localparam logic [7:0] KDB_A_DEBOUNCE = 8'h00;
  localparam logic [7:0] KDB_A_SCAN_CTRL = 8'h04;
  localparam logic [7:0] KDB_A_SCAN_PINEN = 8'h08;
  localparam logic [7:0] KDB_A_GEN_CTRL = 8'h0C;
  localparam logic [7:0] KDB_A_GEN_SEL = 8'h10;
  localparam logic [7:0] KDB_A_IRQ_STAT = 8'h14;
  localparam logic [7:0] KDB_A_IRQ_CLR = 8'h18;
  localparam logic [7:0] KDB_A_IRQ_EN = 8'h1C;
  localparam logic [7:0] KDB_A_PINS = 8'h20;
  // Debounce register fields
  localparam int KDB_F_DEB_SCAN_EN = 6;
  localparam int KDB_F_DEB_GEN_EN = 8;
  // Scan control fields
  localparam int KDB_F_SCAN_LEVEL = 0;
  localparam int KDB_F_SCAN_REL = 1;
  localparam int KDB_F_SCAN_RPT = 8;
  // Generator control: polarity at [4:0], edge mode at [12:8]
  localparam int KDB_F_GEN_EDGE = 8;
  // Status bit of the scanner event
  localparam int KDB_F_ST_SCAN = 5;
  // Reset values
  localparam logic [31:0] KDB_RST_ZERO = 32'h0000_0000;
endpackage

//--- kdb_tick.sv
`timescale 1ns/1ps
// Free-running prescaler making one-cycle 1 ms tick
module kdb_tick
  import kdb_pkg::*;
#(
  parameter int CYCLES = KDB_TICK_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Tick out
  output logic tick
);
  logic [31:0] cnt_r; // Cycle count
  logic [31:0] cnt_nxt;

  // Next count wraps at end of period
  always_comb
  begin
    cnt_nxt = (cnt_r == 32'(CYCLES - 1)) ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
  end

  // Register count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_r <= KDB_RST_ZERO;
    else
      cnt_r <= cnt_nxt;
  end

  assign tick = (cnt_r == 32'(CYCLES - 1));
endmodule

//--- kdb_top.sv
// Operation
// - Scan falling edge on enabled pin hits
// - Hit loads debounce, counts 1 ms ticks
// - Still held: reload repeat, interrupt each expiry
// - Release with reporting: debounce then interrupt
// - Debounce bypass; repeat zero stops repeats
// - Debounce time 0 to 63 ms
// - Programmable scan level and release enable
// - Per-pin scan enable; others ignored
// - Five generators, each selects one pin
// - Polarity zero: rising edge hits
// - Generator debounces, fires if still hit
// - Per-generator debounce bypass
// - Flag holds until its clear bit written
// - Edge mode waits for release after clear
`timescale 1ns/1ps
module kdb_top
  import kdb_pkg::*;
#(
  parameter int TICK_CYC = KDB_TICK_CYC,
  parameter int PINS = KDB_PINS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Port pins
  input wire logic [PINS-1:0] pinIn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Interrupts
  output logic [KDB_GENS-1:0] pinEventInterrupt,
  output logic scanInterrupt,
  output logic irq
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_PRESS = 4'b0010,
    S_REPEAT = 4'b0100,
    S_RELEASE = 4'b1000
  } kdb_sst_e;

  // Software registers
  logic [KDB_DEB_W-1:0] debounceTime_r, debounceTime_nxt;
  logic scanDebounceEnable_r, scanDebounceEnable_nxt;
  logic [KDB_GENS-1:0] pinEventDebounceEnable_r, pinEventDebounceEnable_nxt;
  logic scanActiveLevel_r, scanActiveLevel_nxt;
  logic releaseReportEnable_r, releaseReportEnable_nxt;
  logic [KDB_DEB_W-1:0] repeatTime_r, repeatTime_nxt;
  logic [PINS-1:0] scanPinEnable_r, scanPinEnable_nxt;
  logic [KDB_GENS-1:0] pinEventPolarity_r, pinEventPolarity_nxt;
  logic [KDB_GENS-1:0] edgeModeSelect_r, edgeModeSelect_nxt;
  logic [KDB_SEL_W*KDB_GENS-1:0] pinEventInputSelect_r, pinEventInputSelect_nxt;
  logic [KDB_GENS:0] stat_r, stat_nxt; // Sticky flags
  logic [KDB_GENS:0] irqEn_r, irqEn_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [KDB_GENS:0] clrBits; // Write-one-to-clear pulse
  logic [KDB_GENS:0] events;
  logic tick;

  // Scanner state
  kdb_sst_e sst_r, sst_nxt;
  logic [KDB_DEB_W-1:0] scnt_r, scnt_nxt;
  logic [PINS-1:0] pinPrev_r;
  logic [PINS-1:0] scanLvl;
  logic keyHit, keyFall, scanEvt;

  // Shared 1 ms tick
  kdb_tick #(.CYCLES(TICK_CYC)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // Scan level: pressed means pin equals active level
  assign scanLvl = scanActiveLevel_r ? pinIn : ~pinIn;
  assign keyHit = |(scanLvl & scanPinEnable_r);
  // Pressed edge on an enabled pin
  assign keyFall = |(scanLvl & ~(scanActiveLevel_r ? pinPrev_r : ~pinPrev_r) & scanPinEnable_r);

  // Generators, one per interrupt line
  genvar g;
  generate
    for (g = 0; g < KDB_GENS; g++)
    begin : gen_ev
      logic [KDB_SEL_W-1:0] sel;
      logic selPin;
      assign sel = pinEventInputSelect_r[g*KDB_SEL_W +: KDB_SEL_W];
      assign selPin = (int'(sel) < PINS) ? pinIn[sel] : 1'b0;
      kdb_gen u_gen (
        .clk(clk),
        .rst(rst),
        .tick(tick),
        .pinIn(selPin),
        .polarity(pinEventPolarity_r[g]),
        .debEn(pinEventDebounceEnable_r[g]),
        .edgeMode(edgeModeSelect_r[g]),
        .debTime(debounceTime_r),
        .flagClear(clrBits[g]),
        .fire(events[g])
      );
    end
  endgenerate

  // Scanner next state
  always_comb
  begin
    sst_nxt = sst_r;
    scnt_nxt = scnt_r;
    scanEvt = 1'b0;
    unique case (sst_r)
      S_IDLE:
      begin
        if (keyFall)
        begin
          // Bypass when debounce disabled
          if (!scanDebounceEnable_r || debounceTime_r == '0)
          begin
            scanEvt = 1'b1;
            scnt_nxt = repeatTime_r;
            sst_nxt = S_REPEAT;
          end
          else
          begin
            scnt_nxt = debounceTime_r;
            sst_nxt = S_PRESS;
          end
        end
      end
      S_PRESS:
      begin
        if (tick && scnt_r != '0)
          scnt_nxt = scnt_r - 6'(1);
        if (tick && scnt_r == 6'(1))
        begin
          if (keyHit)
          begin
            scanEvt = 1'b1;
            scnt_nxt = repeatTime_r;
            sst_nxt = S_REPEAT;
          end
          else
            sst_nxt = S_IDLE; // Bounce, no press
        end
      end
      S_REPEAT:
      begin
        if (!keyHit)
        begin
          if (releaseReportEnable_r)
          begin
            if (!scanDebounceEnable_r || debounceTime_r == '0)
            begin
              scanEvt = 1'b1;
              sst_nxt = S_IDLE;
            end
            else
            begin
              scnt_nxt = debounceTime_r;
              sst_nxt = S_RELEASE;
            end
          end
          else
            sst_nxt = S_IDLE;
        end
        else if (tick && repeatTime_r != '0)
        begin
          if (scnt_r <= 6'(1))
          begin
            scanEvt = 1'b1;
            scnt_nxt = repeatTime_r;
          end
          else
            scnt_nxt = scnt_r - 6'(1);
        end
      end
      S_RELEASE:
      begin
        if (tick)
        begin
          scnt_nxt = scnt_r - 6'(1);
          if (scnt_r == 6'(1))
          begin
            scanEvt = 1'b1;
            sst_nxt = S_IDLE;
          end
        end
      end
    endcase
  end

  assign events[KDB_F_ST_SCAN] = scanEvt;

  // Register writes, flags and read data
  always_comb
  begin
    debounceTime_nxt = debounceTime_r;
    scanDebounceEnable_nxt = scanDebounceEnable_r;
    pinEventDebounceEnable_nxt = pinEventDebounceEnable_r;
    scanActiveLevel_nxt = scanActiveLevel_r;
    releaseReportEnable_nxt = releaseReportEnable_r;
    repeatTime_nxt = repeatTime_r;
    scanPinEnable_nxt = scanPinEnable_r;
    pinEventPolarity_nxt = pinEventPolarity_r;
    edgeModeSelect_nxt = edgeModeSelect_r;
    pinEventInputSelect_nxt = pinEventInputSelect_r;
    irqEn_nxt = irqEn_r;
    clrBits = '0;
    rdata_nxt = 32'h0000_0000;
    if (regWr)
    begin
      unique case (regAddr)
        KDB_A_DEBOUNCE:
        begin
          debounceTime_nxt = regWdata[KDB_DEB_W-1:0];
          scanDebounceEnable_nxt = regWdata[KDB_F_DEB_SCAN_EN];
          pinEventDebounceEnable_nxt = regWdata[KDB_F_DEB_GEN_EN +: KDB_GENS];
        end
        KDB_A_SCAN_CTRL:
        begin
          scanActiveLevel_nxt = regWdata[KDB_F_SCAN_LEVEL];
          releaseReportEnable_nxt = regWdata[KDB_F_SCAN_REL];
          repeatTime_nxt = regWdata[KDB_F_SCAN_RPT +: KDB_DEB_W];
        end
        KDB_A_SCAN_PINEN: scanPinEnable_nxt = regWdata[PINS-1:0];
        KDB_A_GEN_CTRL:
        begin
          pinEventPolarity_nxt = regWdata[KDB_GENS-1:0];
          edgeModeSelect_nxt = regWdata[KDB_F_GEN_EDGE +: KDB_GENS];
        end
        KDB_A_GEN_SEL: pinEventInputSelect_nxt = regWdata[KDB_SEL_W*KDB_GENS-1:0];
        KDB_A_IRQ_CLR: clrBits = regWdata[KDB_GENS:0];
        KDB_A_IRQ_EN: irqEn_nxt = regWdata[KDB_GENS:0];
        default: ;
      endcase
    end
    // Set wins over clear; only addressed flags clear
    stat_nxt = (stat_r & ~clrBits) | events;
    if (regRd)
    begin
      unique case (regAddr)
        KDB_A_DEBOUNCE: rdata_nxt = {19'h0, pinEventDebounceEnable_r, 1'b0, scanDebounceEnable_r, debounceTime_r};
        KDB_A_SCAN_CTRL: rdata_nxt = {18'h0, repeatTime_r, 6'h0, releaseReportEnable_r, scanActiveLevel_r};
        KDB_A_SCAN_PINEN: rdata_nxt = 32'(scanPinEnable_r);
        KDB_A_GEN_CTRL: rdata_nxt = {19'h0, edgeModeSelect_r, 3'h0, pinEventPolarity_r};
        KDB_A_GEN_SEL: rdata_nxt = 32'(pinEventInputSelect_r);
        KDB_A_IRQ_STAT: rdata_nxt = 32'(stat_r);
        KDB_A_IRQ_EN: rdata_nxt = 32'(irqEn_r);
        KDB_A_PINS: rdata_nxt = 32'(pinIn);
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Register everything
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      debounceTime_r <= '0;
      scanDebounceEnable_r <= 1'b0;
      pinEventDebounceEnable_r <= '0;
      scanActiveLevel_r <= 1'b0;
      releaseReportEnable_r <= 1'b0;
      repeatTime_r <= '0;
      scanPinEnable_r <= '0;
      pinEventPolarity_r <= '0;
      edgeModeSelect_r <= '0;
      pinEventInputSelect_r <= '0;
      stat_r <= '0;
      irqEn_r <= '0;
      rdata_r <= KDB_RST_ZERO;
      sst_r <= S_IDLE;
      scnt_r <= '0;
      pinPrev_r <= '1;
    end
    else
    begin
      debounceTime_r <= debounceTime_nxt;
      scanDebounceEnable_r <= scanDebounceEnable_nxt;
      pinEventDebounceEnable_r <= pinEventDebounceEnable_nxt;
      scanActiveLevel_r <= scanActiveLevel_nxt;
      releaseReportEnable_r <= releaseReportEnable_nxt;
      repeatTime_r <= repeatTime_nxt;
      scanPinEnable_r <= scanPinEnable_nxt;
      pinEventPolarity_r <= pinEventPolarity_nxt;
      edgeModeSelect_r <= edgeModeSelect_nxt;
      pinEventInputSelect_r <= pinEventInputSelect_nxt;
      stat_r <= stat_nxt;
      irqEn_r <= irqEn_nxt;
      rdata_r <= rdata_nxt;
      sst_r <= sst_nxt;
      scnt_r <= scnt_nxt;
      pinPrev_r <= pinIn;
    end
  end

  // Outputs from read data and flags
  assign regRdata = rdata_r;
  assign pinEventInterrupt = stat_r[KDB_GENS-1:0];
  assign scanInterrupt = stat_r[KDB_F_ST_SCAN];
  assign irq = |(stat_r & irqEn_r);

  property p_sc_load;
    @(posedge clk) disable iff (rst) (sst_r == S_IDLE && keyFall && scanDebounceEnable_r && debounceTime_r != '0)
      |=> (sst_r == S_PRESS && scnt_r == $past(debounceTime_r));
  endproperty
  a_sc_load: assert property (p_sc_load) else $error("scanner did not load debounce time");
  property p_sc_hit;
    @(posedge clk) disable iff (rst) (sst_r == S_IDLE && scanPinEnable_r == '0) |=> (sst_r == S_IDLE);
  endproperty
  a_sc_hit: assert property (p_sc_hit) else $error("scanner left idle with no pin enabled");
  property p_sc_norpt;
    @(posedge clk) disable iff (rst) (sst_r == S_REPEAT && keyHit && repeatTime_r == '0) |-> !scanEvt;
  endproperty
  a_sc_norpt: assert property (p_sc_norpt) else $error("repeat fired with zero interval");
  property p_sc_rel;
    @(posedge clk) disable iff (rst) (sst_r == S_REPEAT && !keyHit && !releaseReportEnable_r)
      |=> (sst_r == S_IDLE && !$past(scanEvt));
  endproperty
  a_sc_rel: assert property (p_sc_rel) else $error("release reported while disabled");
  property p_st_hold;
    @(posedge clk) disable iff (rst) (stat_r[0] && !(regWr && regAddr == KDB_A_IRQ_CLR && regWdata[0]))
      |=> stat_r[0];
  endproperty
  a_st_hold: assert property (p_st_hold) else $error("flag dropped without its clear");
  property p_st_set;
    @(posedge clk) disable iff (rst) events[1] |=> stat_r[1];
  endproperty
  a_st_set: assert property (p_st_set) else $error("event lost");
endmodule

//--- key_debounce_irq_unit_tb.sv
`timescale 1ns/1ps
module key_debounce_irq_unit_tb;
  import kdb_pkg::*;
  localparam int TK = 4; // Short tick for simulation
  logic clk, rst, regWr, regRd, bounce, scanInterrupt, irq;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rv;
  logic [11:0] press, pinIn;
  logic [4:0] pinEventInterrupt;
  logic [3:0] sel [5]; // Pin chosen by each generator
  int errors, n_tests, seed, n, nd, base;
  wire [5:0] st = {scanInterrupt, pinEventInterrupt};

  kdb_top #(.TICK_CYC(TK)) u_dut (.clk(clk), .rst(rst), .pinIn(pinIn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .pinEventInterrupt(pinEventInterrupt), .scanInterrupt(scanInterrupt), .irq(irq));
  kdb_keys u_keys (.clk(clk), .press(press), .bounce(bounce), .pins(pinIn));

  // Clock
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Watchdog against a hang
  initial
  begin
    #400000;
    errors++;
    results;
  end
  // Verdict and end of run
  task results;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Value compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Timing compare: cycles until flag b rises must fall in lo..hi
  task chkw(input int b, input int lo, input int hi);
    n = 0;
    while (st[b] !== 1'b1 && n <= hi)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, (n < lo) ? lo : ((n > hi) ? hi : n));
  endtask
  // Register write
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1;
    @(posedge clk);
    regWr <= 0;
    #1;
  endtask
  // Register read, data taken in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1;
    @(posedge clk);
    regRd <= 0;
    #1;
    rv = regRdata;
  endtask
  // Idle for c cycles
  task idle(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Earliest and latest flag time for a debounce of d ms
  function automatic int tmin(input int d);
    return (d - 1) * TK;
  endfunction
  function automatic int tmax(input int d);
    return d * TK + 8;
  endfunction
  // Generator select word from the chosen pins
  function automatic logic [31:0] selw();
    selw = '0;
    for (int i = 0; i < 5; i++)
      selw[4*i+:4] = sel[i];
  endfunction

  initial
  begin
    rst = 1;
    regWr = 0;
    regRd = 0;
    regAddr = '0;
    regWdata = '0;
    press = '0;
    bounce = 0;
    errors = 0;
    n_tests = 0;
    seed = 32'ha75313fc;
    repeat (2) @(posedge clk);
    rst <= 0;
    // Reset values, read-only status and unmapped place
    for (int a = 0; a <= 36; a += 4)
    begin
      rd(8'(a));
      chk(rv, KDB_RST_ZERO);
    end
    wr(KDB_A_IRQ_STAT, 32'hFFFF_FFFF);
    wr(8'h24, 32'hFFFF_FFFF);
    rd(KDB_A_IRQ_STAT);
    chk(rv, KDB_RST_ZERO);
    rd(8'h24);
    chk(rv, KDB_RST_ZERO);
    rv = $random(seed);
    wr(KDB_A_DEBOUNCE, rv);
    rd(KDB_A_DEBOUNCE);
    chk(rv, regWdata & 32'h0000_1F7F);
    // Five generators on random pins, random debounce time
    base = (($random(seed)) & 32'h7FFF_FFFF) % 12;
    nd = 2 + ($random(seed) & 3);
    for (int i = 0; i < 5; i++)
      sel[i] = 4'((base + i) % 12);
    wr(KDB_A_DEBOUNCE, 32'h0000_1F00 | nd);
    wr(KDB_A_GEN_SEL, selw());
    wr(KDB_A_GEN_CTRL, 32'h0000_0100);
    for (int g = 0; g < 5; g++)
    begin
      @(posedge clk);
      press[sel[g]] <= 1;
      chkw(g, tmin(nd), tmax(nd));
      chk(st, 6'((1 << (g + 1)) - 1));
    end
    // Clear only generator 0, then level mode refire on generator 1
    wr(KDB_A_IRQ_CLR, 32'h0000_0001);
    chk(st, 6'h1E);
    wr(KDB_A_IRQ_CLR, 32'h0000_0002);
    chkw(1, tmin(nd), tmax(nd));
    idle(12 * TK);
    chk(st[0], 1'b0);
    // Flip polarity while waiting for release, then catch the falling edge
    wr(KDB_A_GEN_CTRL, 32'h0000_0101);
    idle(4);
    @(posedge clk);
    press[sel[0]] <= 0;
    chkw(0, tmin(nd), tmax(nd));
    // Back to all edge mode, pins low, all flags clear
    wr(KDB_A_GEN_CTRL, 32'h0000_1F00);
    press <= '0;
    idle(4);
    wr(KDB_A_IRQ_CLR, 32'h0000_003F);
    rd(KDB_A_IRQ_STAT);
    chk(rv, KDB_RST_ZERO);
    // A pulse shorter than the debounce is dropped
    @(posedge clk);
    press[sel[2]] <= 1;
    idle(2);
    press[sel[2]] <= 0;
    idle(nd * TK + 10);
    chk(st[2], 1'b0);
    // Bypass on generator 3 only, long time on the others
    wr(KDB_A_DEBOUNCE, 32'h0000_173F);
    @(posedge clk);
    press[sel[3]] <= 1;
    press[sel[4]] <= 1;
    chkw(3, 0, 4);
    chk(st[4], 1'b0);
    // Interrupt output: masked, enabled, cleared
    wr(KDB_A_IRQ_EN, 32'h0000_0010);
    chk(irq, 1'b0);
    wr(KDB_A_IRQ_EN, 32'h0000_0008);
    chk(irq, 1'b1);
    wr(KDB_A_IRQ_CLR, 32'h0000_0008);
    chk(irq, 1'b0);
    press <= '0;
    idle(4);
    wr(KDB_A_IRQ_CLR, 32'h0000_003F);
    // Scanner on one enabled pin, another pin not enabled
    @(posedge clk);
    press[sel[0]] <= 1;
    press[sel[1]] <= 1;
    wr(KDB_A_SCAN_PINEN, 32'(1) << sel[0]);
    wr(KDB_A_SCAN_CTRL, 32'h0000_0202);
    wr(KDB_A_DEBOUNCE, 32'h0000_0042);
    bounce <= 1;
    press[sel[1]] <= 0;
    idle(20);
    chk(st[5], 1'b0);
    @(posedge clk);
    press[sel[0]] <= 0;
    chkw(5, tmin(2), tmax(2));
    rd(KDB_A_PINS);
    chk(rv, {20'h0_0000, press});
    wr(KDB_A_IRQ_CLR, 32'h0000_0020);
    chkw(5, tmin(2), tmax(2));
    bounce <= 0;
    wr(KDB_A_IRQ_CLR, 32'h0000_0020);
    press[sel[0]] <= 1;
    chkw(5, tmin(2), tmax(2));
    wr(KDB_A_IRQ_CLR, 32'h0000_0020);
    // No debounce, no repeat, no release report
    wr(KDB_A_SCAN_CTRL, 32'h0000_0000);
    wr(KDB_A_DEBOUNCE, 32'h0000_0002);
    @(posedge clk);
    press[sel[0]] <= 0;
    chkw(5, 0, 4);
    wr(KDB_A_IRQ_CLR, 32'h0000_0020);
    idle(10 * TK);
    chk(st[5], 1'b0);
    @(posedge clk);
    press[sel[0]] <= 1;
    idle(10 * TK);
    chk(st[5], 1'b0);
    // Active level high: rising edge presses
    @(posedge clk);
    press[sel[0]] <= 0;
    wr(KDB_A_SCAN_CTRL, 32'h0000_0001);
    idle(4);
    wr(KDB_A_IRQ_CLR, 32'h0000_0020);
    press[sel[0]] <= 1;
    chkw(5, 0, 4);
    results;
  end
endmodule
